// [verilog/emp_pkg.sv]
// Package of constants and types for the experiment message protocol engine
package emp_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 250_000_000;
  localparam int unsigned BAUD_BPS  = 38_400;
  localparam int unsigned BIT_CYC   = CLK_HZ / BAUD_BPS;
  localparam int unsigned GAP_BYTES = 4;
  localparam int unsigned GAP_CYC   = GAP_BYTES * 10 * BIT_CYC;
  // ----------------------------------------------------------------------
  // Layout
  // ----------------------------------------------------------------------
  localparam int unsigned CMD_LEN   = 16;
  localparam int unsigned REP_LEN   = 8;
  localparam int unsigned TYPE_LEN  = 2;
  localparam int unsigned CK_LEN    = 2;
  localparam int unsigned HK_MAX    = 58;
  localparam int unsigned FRM_MAX   = 868;
  localparam logic [15:0] MSG_VERSION_DEF = 16'h0068;
  localparam logic [15:0] SW_BUILD_DEF    = 16'h0001;
  // Two-character codes, first character in the low byte
  localparam logic [15:0] CODE_HOUSEKEEPING_REQUEST = 16'h4848;
  localparam logic [15:0] CODE_PACKET_REQUEST       = 16'h5050;
  localparam logic [15:0] CODE_PACKET_RESEND        = 16'h5252;
  localparam logic [15:0] CODE_SAFE_MODE_NOTICE     = 16'h5A5A;
  localparam logic [15:0] CODE_ACK_REPLY            = 16'h5959;
  localparam logic [15:0] CODE_NOT_READY_REPLY      = 16'h4E4E;
  localparam logic [15:0] CODE_DETECTOR_FAILED      = 16'h4646;
  localparam logic [15:0] CODE_MALFORMED_REPLY      = 16'h5555;
  localparam logic [15:0] CODE_DETECTOR_DATA_TYPE   = 16'h4444;
  localparam logic [15:0] CODE_HOUSEKEEPING_TYPE    = 16'h4848;
  localparam logic [15:0] SIZE_RESET                = 16'h0000;

  typedef struct packed {
    logic [15:0] size;
    logic [15:0] code;
    logic [15:0] build;
    logic [15:0] version;
  } emp_reply_t;

  typedef enum logic [1:0] {
    SRC_HK  = 2'h0,
    SRC_PKT = 2'h1,
    SRC_BUF = 2'h2
  } emp_src_t;
endpackage

// [verilog/emp_uart.sv]
// Byte serialiser and deserialiser, 8N1, least significant bit first
`timescale 1ns/10ps
module emp_uart #(
  parameter int unsigned BIT_CYC = emp_pkg::BIT_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       rxd_i,
  output logic            txd_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_start_i,
  output logic            tx_busy_o
);
  localparam int unsigned CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  logic [CW-1:0] rx_cnt_r;
  logic [3:0]    rx_bit_r;
  logic [7:0]    rx_sh_r;
  logic          rx_act_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_r   <= '0;
      rx_bit_r   <= 4'h0;
      rx_sh_r    <= 8'h00;
      rx_act_r   <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_byte_o  <= 8'h00;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rx_act_r) begin
        if (!rxd_i) begin
          rx_act_r <= 1'b1;
          rx_cnt_r <= HALF;
          rx_bit_r <= 4'h0;
        end
      end else if (rx_cnt_r != '0) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= FULL;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          if (rxd_i) rx_act_r <= 1'b0;  // Glitch, not a start bit
        end else if (rx_bit_r <= 4'h8) begin
          rx_sh_r <= {rxd_i, rx_sh_r[7:1]};
        end else begin
          rx_act_r <= 1'b0;
          if (rxd_i) begin
            rx_valid_o <= 1'b1;  // Framing errors dropped silently
            rx_byte_o  <= rx_sh_r;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  logic [CW-1:0] tx_cnt_r;
  logic [3:0]    tx_bit_r;
  logic [9:0]    tx_sh_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cnt_r  <= '0;
      tx_bit_r  <= 4'h0;
      tx_sh_r   <= 10'h3FF;
      tx_busy_o <= 1'b0;
      txd_o     <= 1'b1;
    end else if (!tx_busy_o) begin
      if (tx_start_i) begin
        tx_sh_r   <= {1'b1, tx_byte_i, 1'b0};
        tx_busy_o <= 1'b1;
        tx_cnt_r  <= FULL;
        tx_bit_r  <= 4'h0;
        txd_o     <= 1'b0;
      end
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end else begin
      tx_cnt_r <= FULL;
      tx_bit_r <= tx_bit_r + 4'h1;
      tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
      txd_o    <= tx_sh_r[1];
      if (tx_bit_r == 4'h9) begin
        tx_busy_o <= 1'b0;
        txd_o     <= 1'b1;
      end
    end
  end
endmodule

// [verilog/emp_engine.sv]
// Experiment-side command interpreter: parses host commands, builds replies
`timescale 1ns/10ps
module emp_engine
  import emp_pkg::*;
#(
  parameter int unsigned BIT_CYC     = emp_pkg::BIT_CYC,
  parameter int unsigned GAP_CYC     = emp_pkg::GAP_CYC,
  parameter logic [15:0] MSG_VERSION = emp_pkg::MSG_VERSION_DEF,
  parameter logic [15:0] SW_BUILD    = emp_pkg::SW_BUILD_DEF
) (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            rxd_i,
  output logic                 txd_o,
  input  wire logic            det_ready_i,
  input  wire logic            det_failed_i,
  input  wire logic [5:0]      hk_len_i,
  input  wire logic [9:0]      pkt_len_i,
  output emp_pkg::emp_src_t    rd_src_o,
  output logic [9:0]           rd_addr_o,
  input  wire logic [7:0]      rd_data_i,
  output logic                 safe_mode_o,
  output logic                 fs_close_o
);
  import emp_pkg::*;

  typedef enum logic [4:0] {
    ST_RX    = 5'h01,
    ST_EVAL  = 5'h02,
    ST_FETCH = 5'h04,
    ST_LOAD  = 5'h08,
    ST_WAIT  = 5'h10
  } emp_state_t;

  emp_state_t  st_r;
  emp_reply_t  rep_r;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        tx_busy;
  logic        tx_start;
  logic [7:0]  tx_byte;
  logic [7:0]  cmd_r [CMD_LEN];
  logic [4:0]  rx_cnt_r;
  logic [$clog2(GAP_CYC+1)-1:0] gap_r;
  logic        short_r;
  logic [10:0] idx_r;
  logic [9:0]  len_r;
  logic [15:0] ck_r;
  logic        prev_pp_r;
  logic        have_frm_r;
  logic [9:0]  frm_len_r;
  logic [7:0]  frm_mem [FRM_MAX];

  emp_uart #(.BIT_CYC(BIT_CYC)) u_uart (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .rxd_i      (rxd_i),
    .txd_o      (txd_o),
    .rx_byte_o  (rx_byte),
    .rx_valid_o (rx_valid),
    .tx_byte_i  (tx_byte),
    .tx_start_i (tx_start),
    .tx_busy_o  (tx_busy)
  );

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic [15:0] rx_ver, rx_code, rx_ck, rx_sum;
  logic        ver_ok, ck_ok, cmd_ok;
  logic [9:0]  hk_len_c;
  // Size field must agree with the clamped byte count actually sent
  assign hk_len_c = (hk_len_i > 6'(HK_MAX)) ? 10'(HK_MAX) : {4'h0, hk_len_i};
  always_comb begin
    rx_sum = 16'h0000;
    for (int i = 0; i < CMD_LEN - CK_LEN; i++) begin
      rx_sum = rx_sum + {8'h00, cmd_r[i]};
    end
  end
  assign rx_ver  = {cmd_r[1], cmd_r[0]};
  assign rx_code = {cmd_r[5], cmd_r[4]};
  assign rx_ck   = {cmd_r[15], cmd_r[14]};
  assign ver_ok  = (rx_ver == MSG_VERSION);
  assign ck_ok   = (rx_ck == rx_sum);
  // Zero build is out of range, treated as malformed
  assign cmd_ok  = !short_r && ver_ok && ck_ok && ({cmd_r[3], cmd_r[2]} != 16'h0000);

  // ----------------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_r <= 5'h00;
      gap_r    <= '0;
      short_r  <= 1'b0;
    end else if (st_r == ST_RX) begin
      if (rx_valid) begin
        cmd_r[rx_cnt_r[3:0]] <= rx_byte;
        rx_cnt_r <= rx_cnt_r + 5'h01;
        gap_r    <= '0;
      end else if (rx_cnt_r != 5'h00) begin
        gap_r <= gap_r + 1'b1;
        if (gap_r == ($bits(gap_r))'(GAP_CYC)) short_r <= 1'b1;
      end
    end else begin
      // Bytes arriving while a reply goes out are not part of any message
      rx_cnt_r <= 5'h00;
      gap_r    <= '0;
      short_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Reply selection
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rep_r       <= '{size: SIZE_RESET, code: CODE_MALFORMED_REPLY,
                       build: SW_BUILD, version: MSG_VERSION};
      len_r       <= 10'h000;
      rd_src_o    <= SRC_HK;
      prev_pp_r   <= 1'b0;
      safe_mode_o <= 1'b0;
      fs_close_o  <= 1'b0;
    end else begin
      fs_close_o <= 1'b0;
      if (st_r == ST_EVAL) begin
        rep_r.version <= MSG_VERSION;
        rep_r.build   <= SW_BUILD;
        rep_r.size    <= SIZE_RESET;
        len_r         <= 10'h000;
        prev_pp_r     <= 1'b0;
        rep_r.code    <= CODE_MALFORMED_REPLY;
        if (cmd_ok) begin
          case (rx_code)
            CODE_HOUSEKEEPING_REQUEST: begin
              rep_r.code <= CODE_ACK_REPLY;
              rep_r.size <= 16'(hk_len_c) + 16'(TYPE_LEN + CK_LEN);
              len_r      <= hk_len_c;
              rd_src_o   <= SRC_HK;
            end
            CODE_PACKET_REQUEST: begin
              prev_pp_r <= 1'b1;
              if (det_failed_i) begin
                rep_r.code <= CODE_DETECTOR_FAILED;
              end else if (!det_ready_i || pkt_len_i == 10'h000) begin
                rep_r.code <= CODE_NOT_READY_REPLY;
              end else begin
                rep_r.code <= CODE_ACK_REPLY;
                rep_r.size <= 16'(pkt_len_i) + 16'(TYPE_LEN + CK_LEN);
                len_r      <= pkt_len_i;
                rd_src_o   <= SRC_PKT;
              end
            end
            CODE_PACKET_RESEND: begin
              if (prev_pp_r && have_frm_r) begin
                rep_r.code <= CODE_ACK_REPLY;
                rep_r.size <= 16'(frm_len_r) + 16'(TYPE_LEN + CK_LEN);
                len_r      <= frm_len_r;
                rd_src_o   <= SRC_BUF;
                prev_pp_r  <= 1'b1;
              end
            end
            CODE_SAFE_MODE_NOTICE: begin
              rep_r.code  <= CODE_ACK_REPLY;
              safe_mode_o <= 1'b1;
              fs_close_o  <= 1'b1;
            end
            default: rep_r.code <= CODE_MALFORMED_REPLY;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reply transmission, one reply per received message, rejected ones included
  // ----------------------------------------------------------------------
  logic [10:0] pay_end, blk_end;
  logic [7:0]  pay_byte;
  logic        in_pay;
  assign pay_end  = 11'(REP_LEN + TYPE_LEN) + {1'b0, len_r};
  assign blk_end  = (rep_r.size == SIZE_RESET) ? 11'(REP_LEN) : pay_end + 11'(CK_LEN);
  assign in_pay   = (idx_r >= 11'(REP_LEN + TYPE_LEN)) && (idx_r < pay_end);
  assign pay_byte = (rd_src_o == SRC_BUF) ? frm_mem[rd_addr_o] : rd_data_i;
  assign tx_start = (st_r == ST_LOAD);

  always_comb begin
    case (idx_r)
      11'd0:   tx_byte = rep_r.version[7:0];
      11'd1:   tx_byte = rep_r.version[15:8];
      11'd2:   tx_byte = rep_r.build[7:0];
      11'd3:   tx_byte = rep_r.build[15:8];
      11'd4:   tx_byte = rep_r.code[7:0];
      11'd5:   tx_byte = rep_r.code[15:8];
      11'd6:   tx_byte = rep_r.size[7:0];
      11'd7:   tx_byte = rep_r.size[15:8];
      11'd8:   tx_byte = (rd_src_o == SRC_HK) ? CODE_HOUSEKEEPING_TYPE[7:0]
                                              : CODE_DETECTOR_DATA_TYPE[7:0];
      11'd9:   tx_byte = (rd_src_o == SRC_HK) ? CODE_HOUSEKEEPING_TYPE[15:8]
                                              : CODE_DETECTOR_DATA_TYPE[15:8];
      default: begin
        if (in_pay) tx_byte = pay_byte;
        else if (idx_r == pay_end) tx_byte = ck_r[7:0];
        else tx_byte = ck_r[15:8];
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= ST_RX;
      idx_r      <= 11'h000;
      ck_r       <= 16'h0000;
      rd_addr_o  <= 10'h000;
      have_frm_r <= 1'b0;
      frm_len_r  <= 10'h000;
    end else begin
      case (st_r)
        ST_RX: begin
          if (short_r || (rx_valid && rx_cnt_r == 5'(CMD_LEN - 1))) st_r <= ST_EVAL;
        end
        ST_EVAL: begin
          idx_r     <= 11'h000;
          ck_r      <= 16'h0000;
          rd_addr_o <= 10'h000;
          st_r      <= ST_FETCH;
        end
        ST_FETCH: begin
          if (!tx_busy) st_r <= ST_LOAD;  // Read data settles during this cycle
        end
        ST_LOAD: begin
          if (idx_r >= 11'(REP_LEN) && idx_r < pay_end) begin
            ck_r <= ck_r + {8'h00, tx_byte};
          end
          if (in_pay) begin
            rd_addr_o <= rd_addr_o + 10'h001;
            if (rd_src_o == SRC_PKT) frm_mem[rd_addr_o] <= rd_data_i;
          end
          if (rd_src_o == SRC_PKT && idx_r == pay_end) begin
            have_frm_r <= 1'b1;
            frm_len_r  <= len_r;
          end
          idx_r <= idx_r + 11'h001;
          st_r  <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!tx_busy) st_r <= (idx_r == blk_end) ? ST_RX : ST_FETCH;
        end
        default: st_r <= ST_RX;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic eval_zz, eval_pp;
  assign eval_zz = (st_r == ST_EVAL) && cmd_ok && rx_code == CODE_SAFE_MODE_NOTICE;
  assign eval_pp = (st_r == ST_EVAL) && cmd_ok && rx_code == CODE_PACKET_REQUEST;

  safe_ack_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    eval_zz |=> rep_r.code == CODE_ACK_REPLY && rep_r.size == SIZE_RESET)
    else $error("safe-mode notice not acknowledged");
  safe_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    eval_zz |=> safe_mode_o && fs_close_o ##1 safe_mode_o && !fs_close_o)
    else $error("safe-mode notice did not stop collection");
  bad_version_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r == ST_EVAL && !ver_ok) |=> rep_r.code == CODE_MALFORMED_REPLY)
    else $error("foreign version accepted");
  bad_checksum_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r == ST_EVAL && !ck_ok) |=> rep_r.code == CODE_MALFORMED_REPLY)
    else $error("bad command checksum accepted");
  short_msg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r == ST_RX && short_r) |=> st_r == ST_EVAL ##1 rep_r.code == CODE_MALFORMED_REPLY)
    else $error("short message not rejected");
  det_failed_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (eval_pp && det_failed_i) |=> rep_r.code == CODE_DETECTOR_FAILED && len_r == 10'h000)
    else $error("failed detector not reported");
  one_reply_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r == ST_EVAL) |=> st_r == ST_FETCH && idx_r == 11'h000)
    else $error("reply did not start after a message");
  tx_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (tx_start && idx_r == 11'd4) |-> tx_byte == rep_r.code[7:0])
    else $error("reply code out of place");
  hk_size_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r != ST_EVAL && rd_src_o == SRC_HK) |-> len_r <= 10'(HK_MAX))
    else $error("housekeeping payload too long");
  tx_only_reply_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r == ST_RX || st_r == ST_EVAL) |-> !tx_start)
    else $error("transmit without a request");
endmodule

// [testbench/emp_host_model.sv]
// Host-side serial model: sends command bytes and collects reply bytes
`timescale 1ns/10ps
module emp_host_model #(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic ref_clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  logic [7:0] rx_q[$];
  int         stop_errs = 0;

  // Idle mark level on the command line, as the serial link requires
  initial rxd_o = 1'b1;

  // ----------------------------------------------------------------------
  // Transmit: start, eight data bits, stop
  // ----------------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk_i);
    end
  endtask

  // ----------------------------------------------------------------------
  // Receive: free-running, so a reply that starts early is never missed
  // ----------------------------------------------------------------------
  initial begin : rx_loop
    logic [7:0] b;
    forever begin
      @(negedge txd_i);
      repeat (BIT_CYC / 2) @(posedge ref_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge ref_clk_i);
        b[i] = txd_i;
      end
      repeat (BIT_CYC) @(posedge ref_clk_i);
      if (txd_i !== 1'b1) stop_errs++;
      rx_q.push_back(b);
    end
  end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the experiment message protocol engine
`timescale 1ns/10ps
module tb;
  import emp_pkg::*;
  localparam int unsigned BC = 8;

  logic       ref_clk_i    = 1'b0;
  logic       rst_n_i      = 1'b0;
  logic       rxd;
  logic       txd;
  logic       det_ready_i  = 1'b1;
  logic       det_failed_i = 1'b0;
  logic [5:0] hk_len_i     = 6'h01;
  logic [9:0] pkt_len_i    = 10'h001;
  emp_src_t   rd_src_o;
  logic [9:0] rd_addr_o;
  logic [7:0] rd_data_i    = 8'h00;
  logic       safe_mode_o;
  logic       fs_close_o;
  logic [7:0] salt         = 8'h00;
  int         miscompares  = 0;
  int         n_tests      = 0;
  int         fs_cnt       = 0;
  int         inval        = 0;

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  emp_engine #(.BIT_CYC(BC), .GAP_CYC(800)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rxd_i(rxd), .txd_o(txd),
    .det_ready_i(det_ready_i), .det_failed_i(det_failed_i), .hk_len_i(hk_len_i),
    .pkt_len_i(pkt_len_i), .rd_src_o(rd_src_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .safe_mode_o(safe_mode_o), .fs_close_o(fs_close_o));

  emp_host_model #(.BIT_CYC(BC)) u_host (
    .ref_clk_i(ref_clk_i), .txd_i(txd), .rxd_o(rxd));

  // ----------------------------------------------------------------------
  // Payload sources; during a resend the source carries the new salt on purpose
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rd_src_o === SRC_HK) rd_data_i <= rd_addr_o[7:0] + 8'h30;
    else rd_data_i <= rd_addr_o[7:0] ^ salt;
    if (fs_close_o === 1'b1) fs_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks: %0d mismatches: %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Host power cycle, enable off time scaled down to a few clocks
  task automatic power_cycle();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check(safe_mode_o, 1'b0);
    check(txd, 1'b1);
  endtask

  task automatic get_byte(output logic [7:0] b);
    int w;
    w = 0;
    while (u_host.rx_q.size() == 0 && w < 3000) begin
      @(posedge ref_clk_i);
      w++;
    end
    if (w >= 3000) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, 0, 1);
      print_verdict();
    end else begin
      b = u_host.rx_q.pop_front();
    end
  endtask

  // Fault 1 version, 2 zero build, 3 checksum; n below 16 ends short
  task automatic send_cmd(input logic [15:0] code, input int fault, input int n);
    logic [7:0]  m [16];
    logic [15:0] ck;
    {m[1], m[0]} = (fault == 1) ? MSG_VERSION_DEF + 16'h0001 : MSG_VERSION_DEF;
    {m[3], m[2]} = (fault == 2) ? 16'h0000 : SW_BUILD_DEF;
    {m[5], m[4]} = code;
    for (int i = 6; i < 14; i++) m[i] = 8'($urandom);
    ck = 16'h0000;
    for (int i = 0; i < 14; i++) ck = ck + {8'h00, m[i]};
    if (fault == 3) ck = ck + 16'h0001;
    {m[15], m[14]} = ck;
    for (int i = 0; i < n; i++) u_host.send_byte(m[i]);
  endtask

  task automatic expect_reply(input logic [15:0] code, input int len,
                              input logic [15:0] typ, input logic [7:0] s, input logic hk);
    logic [7:0]  h [8];
    logic [7:0]  b;
    logic [7:0]  c;
    logic [7:0]  e;
    logic [15:0] ck;
    for (int i = 0; i < 8; i++) get_byte(h[i]);
    check({h[1], h[0]}, MSG_VERSION_DEF);
    check({h[3], h[2]}, SW_BUILD_DEF);
    check({h[5], h[4]}, code);
    check({h[7], h[6]}, (len < 0) ? 16'h0000 : 16'(len + 4));
    if (len >= 0) begin
      ck = 16'h0000;
      for (int i = 0; i < len + 2; i++) begin
        get_byte(b);
        if (i < 2) e = (i == 1) ? typ[15:8] : typ[7:0];
        else e = hk ? 8'(i - 2) + 8'h30 : 8'(i - 2) ^ s;
        check(b, e);
        ck = ck + {8'h00, e};
      end
      get_byte(b);
      get_byte(c);
      check({c, b}, ck);
    end
    if (code == CODE_ACK_REPLY) inval = 0;
    else inval++;
    if (inval == 3) begin
      inval = 0;
      power_cycle();
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin : main
    int         plen;
    logic [7:0] s_old;
    void'($urandom(62825));
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check(safe_mode_o, 1'b0);
    send_cmd(CODE_PACKET_RESEND, 0, 16);
    expect_reply(CODE_MALFORMED_REPLY, -1, 16'h0000, 8'h00, 1'b0);
    for (int f = 1; f <= 4; f++) begin
      send_cmd((f == 4) ? 16'h4141 : CODE_HOUSEKEEPING_REQUEST, (f == 4) ? 0 : f, 16);
      expect_reply(CODE_MALFORMED_REPLY, -1, 16'h0000, 8'h00, 1'b0);
    end
    send_cmd(CODE_HOUSEKEEPING_REQUEST, 0, 5);
    expect_reply(CODE_MALFORMED_REPLY, -1, 16'h0000, 8'h00, 1'b0);
    // Length at the limit, above it (clamped), then random
    for (int k = 0; k < 3; k++) begin
      plen = (k == 2) ? $urandom_range(57, 1) : HK_MAX;
      hk_len_i <= (k == 1) ? 6'h3F : 6'(plen);
      send_cmd(CODE_HOUSEKEEPING_REQUEST, 0, 16);
      expect_reply(CODE_ACK_REPLY, plen, CODE_HOUSEKEEPING_TYPE, 8'h00, 1'b1);
      check(rd_src_o, SRC_HK);
      check(rd_addr_o, plen);
    end
    // Failed while ready, then not ready, then an empty frame counted as not ready
    for (int m = 0; m < 3; m++) begin
      det_failed_i <= (m == 0);
      det_ready_i  <= (m != 1);
      pkt_len_i    <= (m == 2) ? 10'h000 : 10'h014;
      send_cmd(CODE_PACKET_REQUEST, 0, 16);
      expect_reply((m == 0) ? CODE_DETECTOR_FAILED : CODE_NOT_READY_REPLY, -1,
                   16'h0000, 8'h00, 1'b0);
    end
    det_failed_i <= 1'b0;
    det_ready_i  <= 1'b1;
    plen = $urandom_range(60, 1);
    pkt_len_i <= 10'(plen);
    salt = 8'($urandom);
    send_cmd(CODE_PACKET_REQUEST, 0, 16);
    expect_reply(CODE_ACK_REPLY, plen, CODE_DETECTOR_DATA_TYPE, salt, 1'b0);
    check(rd_src_o, SRC_PKT);
    check(rd_addr_o, plen);
    // Source changes after the frame; a resend must still return the old one
    s_old = salt;
    salt = ~salt;
    pkt_len_i <= 10'h03F;
    for (int r = 0; r < 2; r++) begin
      send_cmd(CODE_PACKET_RESEND, 0, 16);
      expect_reply(CODE_ACK_REPLY, plen, CODE_DETECTOR_DATA_TYPE, s_old, 1'b0);
      check(rd_src_o, SRC_BUF);
    end
    send_cmd(CODE_SAFE_MODE_NOTICE, 0, 16);
    expect_reply(CODE_ACK_REPLY, -1, 16'h0000, 8'h00, 1'b0);
    check(safe_mode_o, 1'b1);
    check(fs_cnt, 1);
    repeat (400) @(posedge ref_clk_i);
    check(u_host.rx_q.size(), 0);
    check(u_host.stop_errs, 0);
    print_verdict();
  end
endmodule
